/* src/tecc_timer_ctrl.sv */
// Purpose: control and configuration logic of a 16-bit timer/event counter
// Assumes: all inputs synchronous to core_clk; software keeps reserved bits zero
// Notes: counter runs only while count_run_enable is set
//
// Summary of operation
// R1: software changes clock_prescale_select only while count_run_enable is 0.
// R2: one write may set count_run_enable and prescale; counting uses new prescale.
// R3: software writes zero to bits 3..6 of the first control register.
// R4: software_trigger acts only in external trigger or one-shot modes.
// R5: software writes zero to bits 3 and 4 of the second control register.
// R6: event count mode counts the external event whatever ext_event_input_enable is.
// R7: ext_event_input_enable and mode change only while stopped; same-value rewrites allowed.
// R8: changing those fields while running is unguaranteed; stop, then rewrite.
// R9: output level and enable change only while stopped; else stop and rewrite.
// R10: output pin follows output_level_invert even while stopped and disabled.
// R11: capture edge fields change only while stopped; else stop and rewrite.
// R12: capture happens only in free-running and pulse width measurement modes.
// R13: event and trigger edge fields change only while stopped; else stop and rewrite.
// R14: event edge select used only when event input enabled or event count mode.
// R15: trigger edge select used only in external trigger or one-shot modes.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module tecc_timer_ctrl #(
    parameter int unsigned CHANNELS = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [tecc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tecc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tecc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic ext_event_in,
    input wire logic ext_trigger_in,
    input wire logic [CHANNELS-1:0] capture_in,
    output logic [CHANNELS-1:0] timer_output_pin,
    output logic [CHANNELS-1:0] capture_strobe,
    output logic start_trigger
);
    initial begin
        if (CHANNELS < 1 || CHANNELS > 4) begin
            $error("CHANNELS must be 1 to 4");
        end
    end

    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        case (sel)
            tecc_pkg::EDGE_RISE: edge_hit = !prev && cur;
            tecc_pkg::EDGE_FALL: edge_hit = prev && !cur;
            tecc_pkg::EDGE_BOTH: edge_hit = prev != cur;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file
    // fields are plain storage: writes are never refused while running,
    // so an illegal rewrite shows up at once in the counting logic.
    // reserved bits are dropped on write and read back as zero.
    logic run_q, run_d;
    logic [2:0] prs_q, prs_d;
    logic eee_q, eee_d;
    tecc_pkg::tecc_mode_t mode_q, mode_d;
    logic [7:0] outctl_q, outctl_d;
    logic [7:0] capctl_q, capctl_d;
    logic [7:0] evtctl_q, evtctl_d;
    logic sw_trig;
    logic [tecc_pkg::CNT_W-1:0] cnt_q, cnt_d;

    always_comb begin
        run_d = run_q;
        prs_d = prs_q;
        eee_d = eee_q;
        mode_d = mode_q;
        outctl_d = outctl_q;
        capctl_d = capctl_q;
        evtctl_d = evtctl_q;
        sw_trig = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                tecc_pkg::OFS_CTL0: begin
                    // run and prescale taken together in one write
                    run_d = reg_wdata[tecc_pkg::CTL0_RUN_BIT]; // R2
                    prs_d = reg_wdata[tecc_pkg::CTL0_PRS_LSB +: 3]; // R2
                end
                tecc_pkg::OFS_CTL1: begin
                    // a rewrite while running is taken as written; software must stop and rewrite
                    eee_d = reg_wdata[tecc_pkg::CTL1_EEE_BIT]; // R8
                    mode_d = tecc_pkg::tecc_mode_t'(reg_wdata[tecc_pkg::CTL1_MODE_LSB +: 3]);
                    // trigger is a write-only pulse, honoured in external trigger and one-shot modes only
                    sw_trig = reg_wdata[tecc_pkg::CTL1_SWTRIG_BIT]
                        && (mode_q == tecc_pkg::TECC_MODE_EXT_TRIG
                        || mode_q == tecc_pkg::TECC_MODE_ONE_SHOT); // R4
                end
                tecc_pkg::OFS_OUTCTL: outctl_d = reg_wdata[7:0];
                tecc_pkg::OFS_CAPCTL: capctl_d = reg_wdata[7:0];
                tecc_pkg::OFS_EVTCTL: evtctl_d = {4'h0, reg_wdata[3:0]};
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // count source and counter
    // the external event replaces the prescaled clock as count source when ext_event_input_enable is set or in event count mode,
    // edges are found by comparing two consecutive samples of each input.
    // the counter and prescaler clear whenever counting is stopped.
    logic [6:0] pdiv_q, pdiv_d;
    logic ev_prev_q, tr_prev_q;
    logic [CHANNELS-1:0] cap_prev_q;
    logic use_event, prs_tick, ev_tick, tr_hit, cnt_tick;
    logic [CHANNELS-1:0] tog_q, tog_d;
    logic wrap;

    always_comb begin
        // prescaler is held clear while stopped so a fresh start uses the new ratio
        pdiv_d = run_q ? pdiv_q + 7'h01 : 7'h00; // R2
        prs_tick = run_q && ((pdiv_q & ((7'h01 << prs_q) - 7'h01)) == ((7'h01 << prs_q) - 7'h01));
        use_event = eee_q || mode_q == tecc_pkg::TECC_MODE_EVENT_CNT; // R6 R14
        ev_tick = use_event && edge_hit(evtctl_q[tecc_pkg::EVT_EES_LSB +: 2], ev_prev_q, ext_event_in); // R14
        tr_hit = (mode_q == tecc_pkg::TECC_MODE_EXT_TRIG || mode_q == tecc_pkg::TECC_MODE_ONE_SHOT)
            && edge_hit(evtctl_q[tecc_pkg::EVT_ETS_LSB +: 2], tr_prev_q, ext_trigger_in); // R15
        cnt_tick = run_q && (use_event ? ev_tick : prs_tick); // R6
        wrap = cnt_tick && cnt_q == tecc_pkg::CNT_MAX;
        if (!run_q) begin
            cnt_d = tecc_pkg::CNT_RST;
        end else if (cnt_tick) begin
            cnt_d = cnt_q + 16'h0001;
        end else begin
            cnt_d = cnt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel output and capture
    logic [CHANNELS-1:0] pin_d, cap_d;
    logic capture_mode;
    assign capture_mode = mode_q == tecc_pkg::TECC_MODE_FREE_RUN
        || mode_q == tecc_pkg::TECC_MODE_PULSE_MEAS; // R12

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
            always_comb begin
                // toggle state is only meaningful while running and enabled
                tog_d[gi] = (run_q && outctl_q[2*gi]) ? (tog_q[gi] ^ wrap) : 1'b0;
                // level bit drives the pin directly even with run and enable clear
                pin_d[gi] = outctl_d[2*gi+1] ^ tog_d[gi]; // R10
                cap_d[gi] = run_q && capture_mode
                    && edge_hit(capctl_q[2*gi +: 2], cap_prev_q[gi], capture_in[gi]); // R12
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read data
    // read data stand for one cycle after the read strobe, zero otherwise,
    // so a bus that ors several slaves together sees no stale value.
    logic [tecc_pkg::DATA_W-1:0] rdata_d;

    always_comb begin
        rdata_d = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                tecc_pkg::OFS_CTL0: rdata_d = {8'h00, run_q, 4'h0, prs_q};
                tecc_pkg::OFS_CTL1: rdata_d = {8'h00, 2'h0, eee_q, 2'h0, mode_q};
                tecc_pkg::OFS_OUTCTL: rdata_d = {8'h00, outctl_q};
                tecc_pkg::OFS_CAPCTL: rdata_d = {8'h00, capctl_q};
                tecc_pkg::OFS_EVTCTL: rdata_d = {8'h00, evtctl_q};
                tecc_pkg::OFS_COUNT: rdata_d = cnt_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers
    // every output is taken from a flip-flop here; the pin level
    // follows a write of the level bit one cycle later, even when stopped.
    // the trigger pulse lasts exactly one cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            prs_q <= tecc_pkg::PRS_RST;
            eee_q <= 1'b0;
            mode_q <= tecc_pkg::TECC_MODE_INTERVAL;
            outctl_q <= tecc_pkg::REG8_RST;
            capctl_q <= tecc_pkg::REG8_RST;
            evtctl_q <= tecc_pkg::REG8_RST;
            pdiv_q <= 7'h00;
            cnt_q <= tecc_pkg::CNT_RST;
            ev_prev_q <= 1'b0;
            tr_prev_q <= 1'b0;
            cap_prev_q <= '0;
            tog_q <= '0;
            timer_output_pin <= '0;
            capture_strobe <= '0;
            start_trigger <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            run_q <= run_d;
            prs_q <= prs_d;
            eee_q <= eee_d;
            mode_q <= mode_d;
            outctl_q <= outctl_d;
            capctl_q <= capctl_d;
            evtctl_q <= evtctl_d;
            pdiv_q <= pdiv_d;
            cnt_q <= cnt_d;
            ev_prev_q <= ext_event_in;
            tr_prev_q <= ext_trigger_in;
            cap_prev_q <= capture_in;
            tog_q <= tog_d;
            timer_output_pin <= pin_d; // R10
            capture_strobe <= cap_d; // R12
            start_trigger <= run_q && (sw_trig || tr_hit); // R4 R15
            reg_rdata <= rdata_d;
        end
    end
endmodule

/* src/tecc_pkg.sv */
// Purpose: constants shared by the timer/event counter control block
// Assumes: plain register port, 8-bit control registers, 16-bit counter
// Notes: register offsets are word indices on the plain port
package tecc_pkg;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W = 16;

    // register offsets
    localparam logic [2:0] OFS_CTL0 = 3'h0;
    localparam logic [2:0] OFS_CTL1 = 3'h1;
    localparam logic [2:0] OFS_OUTCTL = 3'h2;
    localparam logic [2:0] OFS_CAPCTL = 3'h3;
    localparam logic [2:0] OFS_EVTCTL = 3'h4;
    localparam logic [2:0] OFS_COUNT = 3'h5;

    // first control register fields
    localparam int unsigned CTL0_RUN_BIT = 7;
    localparam int unsigned CTL0_PRS_LSB = 0;
    // second control register fields
    localparam int unsigned CTL1_SWTRIG_BIT = 6;
    localparam int unsigned CTL1_EEE_BIT = 5;
    localparam int unsigned CTL1_MODE_LSB = 0;
    // event/trigger control fields
    localparam int unsigned EVT_EES_LSB = 2;
    localparam int unsigned EVT_ETS_LSB = 0;

    localparam logic [2:0] PRS_RST = 3'h0;
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

    typedef enum logic [2:0] {
        TECC_MODE_INTERVAL = 3'b000,
        TECC_MODE_EVENT_CNT = 3'b001,
        TECC_MODE_EXT_TRIG = 3'b010,
        TECC_MODE_ONE_SHOT = 3'b011,
        TECC_MODE_PWM = 3'b100,
        TECC_MODE_FREE_RUN = 3'b101,
        TECC_MODE_PULSE_MEAS = 3'b110,
        TECC_MODE_RESERVED = 3'b111
    } tecc_mode_t;

    // edge select codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

/* bench/tecc_chk.sv */
// Purpose: port-level checks of the timer control block
// Assumes: a shadow of the written fields tracks the registers
// Notes: one clock domain
`timescale 1ns/100ps
module tecc_chk #(
    parameter int unsigned CHANNELS = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic ext_trigger_in,
    input wire logic [CHANNELS-1:0] timer_output_pin,
    input wire logic [CHANNELS-1:0] capture_strobe,
    input wire logic start_trigger
);
    logic run_q, run_d, trig_ok, cap_ok;
    logic [2:0] mode_q, mode_d;
    logic [1:0] ets_q, ets_d;
    always_comb begin
        {run_d, mode_d, ets_d} = {run_q, mode_q, ets_q};
        if (reg_wr && reg_addr == tecc_pkg::OFS_CTL0) run_d = reg_wdata[7];
        if (reg_wr && reg_addr == tecc_pkg::OFS_CTL1) mode_d = reg_wdata[2:0];
        if (reg_wr && reg_addr == tecc_pkg::OFS_EVTCTL) ets_d = reg_wdata[1:0];
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) {run_q, mode_q, ets_q} <= '0;
        else {run_q, mode_q, ets_q} <= {run_d, mode_d, ets_d};
    end
    assign trig_ok = run_q && (mode_q == 3'h2 || mode_q == 3'h3);
    assign cap_ok = run_q && (mode_q == 3'h5 || mode_q == 3'h6);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data not idle");
    rd_unmapped_a: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 16'h0000) else $error("unmapped read");
    swtrig_read_a: assert property (reg_rd && reg_addr == tecc_pkg::OFS_CTL1 |=> !reg_rdata[6])
        else $error("trigger bit read back");
    pin_level_a: assert property (reg_wr && reg_addr == tecc_pkg::OFS_OUTCTL && !run_q && !$past(run_q)
        |=> timer_output_pin[0] == $past(reg_wdata[1])) else $error("pin level");
    trig_gate_a: assert property (start_trigger |-> $past(trig_ok)) else $error("trigger outside mode");
    sw_fire_a: assert property (reg_wr && reg_addr == tecc_pkg::OFS_CTL1 && reg_wdata[6] && trig_ok
        |=> start_trigger) else $error("software trigger lost");
    ext_fire_a: assert property (trig_ok && ets_q == tecc_pkg::EDGE_RISE && $rose(ext_trigger_in)
        |-> ##[1:2] start_trigger) else $error("external trigger lost");
    cap_gate_a: assert property (|capture_strobe |-> $past(cap_ok)) else $error("capture outside mode");
endmodule
bind tecc_timer_ctrl tecc_chk #(.CHANNELS(CHANNELS)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_trigger_in(ext_trigger_in), .timer_output_pin(timer_output_pin), .capture_strobe(capture_strobe),
    .start_trigger(start_trigger));

/* bench/tb.sv */
// Purpose: self-checking bench of the timer control block
// Assumes: register map and codes of tecc_pkg
// Notes: scenario tasks run in sequence
`timescale 1ns/100ps
module tb;
    logic core_clk, rst_n, reg_wr, reg_rd, ext_event_in, ext_trigger_in, start_trigger;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [3:0] capture_in, timer_output_pin, capture_strobe;
    int miscompares, total_checks, trig_cnt, cap_cnt;
    tecc_timer_ctrl #(.CHANNELS(4)) dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_event_in(ext_event_in), .ext_trigger_in(ext_trigger_in), .capture_in(capture_in),
        .timer_output_pin(timer_output_pin), .capture_strobe(capture_strobe), .start_trigger(start_trigger));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        trig_cnt += (start_trigger === 1'b1);
        cap_cnt += (capture_strobe[0] === 1'b1);
    end
    ////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
        @(posedge core_clk);
        {reg_wr, reg_rd} <= 2'h0;
        #1;
        if (!w) check(reg_rdata, d);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge core_clk);
            {ext_event_in, ext_trigger_in, capture_in} <= 6'h31;
            repeat (3) @(posedge core_clk);
            {ext_event_in, ext_trigger_in, capture_in} <= 6'h00;
            repeat (3) @(posedge core_clk);
        end
    endtask
    task automatic t_reset();
        for (int a = 0; a < 8; a++) bus(1'b0, 3'(a), 16'h0000);
        bus(1'b1, 3'h7, 16'hffff);
        bus(1'b0, 3'h7, 16'h0000);
    endtask
    task automatic t_out();
        bus(1'b1, 3'h2, 16'h00aa);
        check(16'(timer_output_pin), 16'h000f);
        bus(1'b1, 3'h2, 16'h0022);
        check(16'(timer_output_pin), 16'h0005);
        bus(1'b0, 3'h2, 16'h0022);
    endtask
    task automatic t_prescale();
        bus(1'b1, 3'h0, 16'h0080);
        repeat (20) @(posedge core_clk);
        bus(1'b1, 3'h0, 16'h0000);
        bus(1'b1, 3'h0, 16'h0087);
        repeat (300) @(posedge core_clk);
        bus(1'b0, 3'h5, 16'h0002);
        bus(1'b1, 3'h0, 16'h0000);
    endtask
    task automatic t_event();
        bus(1'b1, 3'h4, 16'h0004);
        bus(1'b1, 3'h1, 16'h0001);
        bus(1'b1, 3'h0, 16'h0087);
        pulse(5);
        bus(1'b0, 3'h5, 16'h0005);
        bus(1'b1, 3'h0, 16'h0007);
        bus(1'b1, 3'h4, 16'h000c);
        bus(1'b1, 3'h1, 16'h0020);
        bus(1'b1, 3'h0, 16'h0087);
        pulse(3);
        bus(1'b0, 3'h5, 16'h0006);
        bus(1'b1, 3'h0, 16'h0000);
    endtask
    task automatic t_modes();
        bus(1'b1, 3'h4, 16'h0001);
        bus(1'b1, 3'h3, 16'h0001);
        for (int m = 0; m < 7; m++) begin
            bus(1'b1, 3'h0, 16'h0000);
            bus(1'b1, 3'h1, 16'(m));
            bus(1'b1, 3'h0, 16'h0080);
            trig_cnt = 0;
            bus(1'b1, 3'h1, 16'(m) | 16'h0040);
            repeat (2) @(posedge core_clk);
            check(16'(trig_cnt), 16'(m == 2 || m == 3));
            trig_cnt = 0;
            cap_cnt = 0;
            pulse(1);
            check(16'(trig_cnt), 16'(m == 2 || m == 3));
            check(16'(cap_cnt), 16'(m == 5 || m == 6));
        end
        bus(1'b1, 3'h0, 16'h0000);
    endtask
    task automatic print_verdict();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, ext_event_in, ext_trigger_in} = 5'h00;
        {reg_addr, reg_wdata, capture_in} = 23'h00_0000;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_out();
        t_prescale();
        t_event();
        t_modes();
        print_verdict();
    end
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
endmodule
